// ---- rtl/crossbar_defs.svh ----
/*
 * Constants for the priority pin crossbar: register offsets, field positions, reset values.
 * Assumes inclusion by bare name from rtl/ files; definitions only.
 */
`ifndef CROSSBAR_DEFS_SVH
`define CROSSBAR_DEFS_SVH

// Register word indices; the byte address on the bus is four times the index
`define OFF_ROUTE_SEL      8'he1
`define OFF_ROUTE_CTRL     8'he2
// Registers of our own for per-pin configuration and latches
`define OFF_PORT0_LATCH    8'h00
`define OFF_PORT1_LATCH    8'h01
`define OFF_INPUT_KIND     8'h02
`define OFF_DRIVER_KIND    8'h03
`define OFF_BYPASS_MASK    8'h04
`define OFF_PIN_STATE      8'h05
`define OFF_SPI_MODE       8'h06
`define OFF_ROUTE_MAP      8'h07

// Reset values
`define RST_ROUTE_SEL      8'h00
`define RST_ROUTE_CTRL     8'h00
`define RST_INPUT_KIND     16'hffff
`define RST_DRIVER_KIND    16'h0000
`define RST_BYPASS_MASK    16'h0000
`define RST_LATCH          16'hffff

// Field positions in peripheral_route_select
`define B_SERIAL_ROUTE     0
`define B_SPI_ROUTE        1
`define B_LIN_ROUTE        2
`define B_SYSTEM_CLOCK_SIGNAL_ROUTE     3
`define B_CMP_SYNC_ROUTE   4
`define B_CMP_ASYNC_ROUTE  5
`define ROUTE_SEL_MASK     8'h3f

// Field positions in route_and_pullup_control
`define B_CAPTURE_LO       0
`define B_CAPTURE_HI       1
`define B_COUNT_ROUTE      3
`define B_T0_ROUTE         4
`define B_T1_ROUTE         5
`define B_CROSSBAR_ON      6
`define B_PULLUP_OFF       7
`define ROUTE_CTRL_MASK    8'hfb

// Fixed serial pins per variant
`define SERIAL_TX_PIN_A    4'h4
`define SERIAL_TX_PIN_B    4'h3

`endif

// ---- rtl/crossbar_pkg.sv ----
/*
 * Types for the priority pin crossbar.
 * Assumes crossbar_defs.svh compiled alongside; no imports anywhere.
 */
`default_nettype none
package crossbar_pkg;
  // Crossbar function slots in descending priority
  typedef enum logic [4:0] {
    FN_SERIAL_TX, FN_SERIAL_RX, FN_SPI_SCK, FN_SPI_MISO, FN_SPI_MOSI, FN_SPI_NSS,
    FN_LIN_TX, FN_SYSTEM_CLOCK_SIGNAL, FN_CMP_SYNC, FN_CMP_ASYNC, FN_CAP0, FN_CAP1, FN_CAP2,
    FN_COUNT_IN, FN_T0_IN, FN_T1_IN, FN_GPIO
  } pin_func_t;

  // Per-pin configuration carried as one bundle
  typedef struct packed {
    logic [15:0] input_kind;
    logic [15:0] driver_kind;
    logic [15:0] bypass;
  } pin_cfg_t;

  // Peripheral-driven outputs into the crossbar
  typedef struct packed {
    logic serial_tx;
    logic spi_sck;
    logic spi_miso;
    logic spi_mosi;
    logic spi_nss;
    logic lin_tx;
    logic system_clock_signal;
    logic cmp_sync;
    logic cmp_async;
    logic [2:0] cap;
  } periph_out_t;

  // Inputs returned to peripherals
  typedef struct packed {
    logic serial_rx;
    logic spi_sck;
    logic spi_miso;
    logic spi_mosi;
    logic spi_nss;
    logic [2:0] cap;
    logic count_in;
    logic t0_in;
    logic t1_in;
  } periph_in_t;
endpackage : crossbar_pkg
`default_nettype wire

// ---- rtl/crossbar_decoder.sv ----
/*
 * Combinational priority decoder: maps each enabled function onto a pin while free pins remain.
 * Assumes a caller that registers its results; pure logic, no clock.
 */
`default_nettype none
`include "crossbar_defs.svh"
module crossbar_decoder (
  input  wire logic [7:0]  route_sel,
  input  wire logic [7:0]  route_ctrl,
  input  wire logic        four_wire,
  input  wire logic        variant_b,
  input  wire logic [15:0] bypass,
  output crossbar_pkg::pin_func_t pin_func [16]
);
  // Priority walk: each enabled slot takes lowest free, unskipped pin
  always_comb begin
    logic [15:0] taken;
    logic [16:0] want;
    logic [3:0]  tx_pin;
    logic        hit;
    taken  = bypass;
    want   = '0;
    tx_pin = variant_b ? `SERIAL_TX_PIN_B : `SERIAL_TX_PIN_A;
    hit    = 1'b0;
    for (int p = 0; p < 16; p++) begin
      pin_func[p] = crossbar_pkg::FN_GPIO;
    end
    // Serial pair sits on fixed pins, both claimed together
    if (route_sel[`B_SERIAL_ROUTE]) begin
      pin_func[tx_pin]             = crossbar_pkg::FN_SERIAL_TX;
      pin_func[4'(tx_pin + 4'd1)]  = crossbar_pkg::FN_SERIAL_RX;
      taken[tx_pin]                = 1'b1;
      taken[4'(tx_pin + 4'd1)]     = 1'b1;
    end
    // Fixed priority table below the serial port
    want[crossbar_pkg::FN_SPI_SCK]   = route_sel[`B_SPI_ROUTE];
    want[crossbar_pkg::FN_SPI_MISO]  = route_sel[`B_SPI_ROUTE];
    want[crossbar_pkg::FN_SPI_MOSI]  = route_sel[`B_SPI_ROUTE];
    want[crossbar_pkg::FN_SPI_NSS]   = route_sel[`B_SPI_ROUTE] & four_wire;
    want[crossbar_pkg::FN_LIN_TX]    = route_sel[`B_LIN_ROUTE];
    want[crossbar_pkg::FN_SYSTEM_CLOCK_SIGNAL]    = route_sel[`B_SYSTEM_CLOCK_SIGNAL_ROUTE];
    want[crossbar_pkg::FN_CMP_SYNC]  = route_sel[`B_CMP_SYNC_ROUTE];
    want[crossbar_pkg::FN_CMP_ASYNC] = route_sel[`B_CMP_ASYNC_ROUTE];
    want[crossbar_pkg::FN_CAP0]      = route_ctrl[`B_CAPTURE_HI:`B_CAPTURE_LO] != 2'b00;
    want[crossbar_pkg::FN_CAP1]      = route_ctrl[`B_CAPTURE_HI];
    want[crossbar_pkg::FN_CAP2]      = route_ctrl[`B_CAPTURE_HI:`B_CAPTURE_LO] == 2'b11;
    want[crossbar_pkg::FN_COUNT_IN]  = route_ctrl[`B_COUNT_ROUTE];
    want[crossbar_pkg::FN_T0_IN]     = route_ctrl[`B_T0_ROUTE];
    want[crossbar_pkg::FN_T1_IN]     = route_ctrl[`B_T1_ROUTE];
    for (int f = crossbar_pkg::FN_SPI_SCK; f <= crossbar_pkg::FN_T1_IN; f++) begin
      hit = 1'b0;
      for (int p = 0; p < 16; p++) begin
        if (want[f] && !hit && !taken[p]) begin
          pin_func[p] = crossbar_pkg::pin_func_t'(f);
          taken[p]    = 1'b1;
          hit         = 1'b1;
        end
      end
    end
  end
endmodule : crossbar_decoder
`default_nettype wire

// ---- rtl/priority_pin_crossbar.sv ----
/*
 * Priority pin crossbar: AXI4-Lite register slave, routing decode and per-pin drivers.
 * Assumes synchronous pin inputs on core_clk; pads resolve output, enable and pullup.
 */
`default_nettype none
`include "crossbar_defs.svh"
module priority_pin_crossbar (
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  input  wire logic                      variant_b,
  // AXI4-Lite slave
  input  wire logic [9:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [9:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Peripheral side
  input  wire crossbar_pkg::periph_out_t periph_out,
  output crossbar_pkg::periph_in_t       periph_in,
  // Pads
  input  wire logic [15:0]               pin_in,
  output logic [15:0]                    pin_out,
  output logic [15:0]                    pin_oe,
  output logic [15:0]                    pin_pullup,
  output logic [15:0]                    pin_analog
);
  // Response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Software-visible registers
  logic [7:0]               route_sel;
  logic [7:0]               route_ctrl;
  logic [15:0]              port_latch;
  crossbar_pkg::pin_cfg_t   cfg;
  logic [1:0]               slave_select_mode;

  // Write channel holding state and word indices
  logic [9:0]               aw_addr;
  logic [7:0]               aw_idx;
  logic [7:0]               ar_idx;
  logic                     wr_ok;
  logic                     aw_held;
  logic [31:0]              w_data;
  logic [3:0]               w_strb;
  logic                     w_held;

  // Decode results and next pad values
  logic [15:0]              pin_seen;
  crossbar_pkg::pin_func_t  pin_func [16];
  crossbar_pkg::pin_func_t  map_sel;
  logic [15:0]              next_out;
  logic [15:0]              next_oe;
  logic [15:0]              next_pu;
  logic [15:0]              fn_oe;
  logic                     do_write;
  logic [31:0]              read_word;
  logic                     read_ok;

  // Write address and data accepted independently, either order
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      aw_addr <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  // Word index of each address; an unaligned one maps to an unused index
  assign aw_idx = (aw_addr[1:0] == 2'b00) ? aw_addr[9:2] : 8'hff;
  assign ar_idx = (s_axi_araddr[1:0] == 2'b00) ? s_axi_araddr[9:2] : 8'hff;
  // Writable words: both routing registers and our own up to the SPI mode
  assign wr_ok  = aw_idx == `OFF_ROUTE_SEL || aw_idx == `OFF_ROUTE_CTRL || aw_idx <= `OFF_SPI_MODE;

  // Ready signals are registered; low while a word is held
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Write response
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Routing registers; reserved bits forced to zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      route_sel  <= `RST_ROUTE_SEL;
      route_ctrl <= `RST_ROUTE_CTRL;
    end else if (do_write && w_strb[0]) begin
      if (aw_idx == `OFF_ROUTE_SEL) begin
        route_sel <= w_data[7:0] & `ROUTE_SEL_MASK;
      end
      if (aw_idx == `OFF_ROUTE_CTRL) begin
        route_ctrl <= w_data[7:0] & `ROUTE_CTRL_MASK;
      end
    end
  end

  // Pin configuration registers, byte lanes per port
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg.input_kind    <= `RST_INPUT_KIND;
      cfg.driver_kind   <= `RST_DRIVER_KIND;
      cfg.bypass        <= `RST_BYPASS_MASK;
      port_latch        <= `RST_LATCH;
      slave_select_mode <= 2'b00;
    end else if (do_write) begin
      for (int b = 0; b < 2; b++) begin
        if (w_strb[b]) begin
          unique case (aw_idx)
            `OFF_INPUT_KIND:  cfg.input_kind[b*8 +: 8]  <= w_data[b*8 +: 8];
            `OFF_DRIVER_KIND: cfg.driver_kind[b*8 +: 8] <= w_data[b*8 +: 8];
            `OFF_BYPASS_MASK: cfg.bypass[b*8 +: 8]      <= w_data[b*8 +: 8];
            default: ;
          endcase
        end
      end
      // Latches and SPI mode use byte lane 0 only
      if (w_strb[0] && aw_idx == `OFF_PORT0_LATCH) begin
        port_latch[7:0] <= w_data[7:0];
      end
      if (w_strb[0] && aw_idx == `OFF_PORT1_LATCH) begin
        port_latch[15:8] <= w_data[7:0];
      end
      if (w_strb[0] && aw_idx == `OFF_SPI_MODE) begin
        slave_select_mode <= w_data[1:0];
      end
    end
  end

  // Read channel: one read at a time, registered answer
  always_comb begin
    read_ok   = 1'b1;
    map_sel   = pin_func[0];
    read_word = 32'h0000_0000;
    unique case (ar_idx)
      `OFF_ROUTE_SEL:   read_word = {24'h00_0000, route_sel};
      `OFF_ROUTE_CTRL:  read_word = {24'h00_0000, route_ctrl};
      `OFF_PORT0_LATCH: read_word = {24'h00_0000, pin_seen[7:0]};
      `OFF_PORT1_LATCH: read_word = {24'h00_0000, pin_seen[15:8]};
      `OFF_INPUT_KIND:  read_word = {16'h0000, cfg.input_kind};
      `OFF_DRIVER_KIND: read_word = {16'h0000, cfg.driver_kind};
      `OFF_BYPASS_MASK: read_word = {16'h0000, cfg.bypass};
      `OFF_PIN_STATE:   read_word = {port_latch, pin_oe};
      `OFF_SPI_MODE:    read_word = {30'h0000_0000, slave_select_mode};
      `OFF_ROUTE_MAP:   read_word = {27'h000_0000, map_sel};
      default:          read_ok   = 1'b0;
    endcase
  end

  // Read answer registered; arready low while the answer stands
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= read_word;
        s_axi_rresp  <= read_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Priority decode of current selections
  crossbar_decoder u_decoder (
    .route_sel  (route_sel),
    .route_ctrl (route_ctrl),
    .four_wire  (slave_select_mode[1]),
    .variant_b  (variant_b),
    .bypass     (cfg.bypass),
    .pin_func   (pin_func)
  );

  // Per-pin output value and enable from the routed function
  for (genvar p = 0; p < 16; p++) begin : g_pin
    always_comb begin
      next_out[p] = port_latch[p];
      fn_oe[p]    = 1'b1;
      unique case (pin_func[p])
        crossbar_pkg::FN_SERIAL_TX: next_out[p] = periph_out.serial_tx;
        crossbar_pkg::FN_SPI_SCK:   next_out[p] = periph_out.spi_sck;
        crossbar_pkg::FN_SPI_MISO:  next_out[p] = periph_out.spi_miso;
        crossbar_pkg::FN_SPI_MOSI:  next_out[p] = periph_out.spi_mosi;
        crossbar_pkg::FN_SPI_NSS:   next_out[p] = periph_out.spi_nss;
        crossbar_pkg::FN_LIN_TX:    next_out[p] = periph_out.lin_tx;
        crossbar_pkg::FN_SYSTEM_CLOCK_SIGNAL:    next_out[p] = periph_out.system_clock_signal;
        crossbar_pkg::FN_CMP_SYNC:  next_out[p] = periph_out.cmp_sync;
        crossbar_pkg::FN_CMP_ASYNC: next_out[p] = periph_out.cmp_async;
        crossbar_pkg::FN_CAP0:      next_out[p] = periph_out.cap[0];
        crossbar_pkg::FN_CAP1:      next_out[p] = periph_out.cap[1];
        crossbar_pkg::FN_CAP2:      next_out[p] = periph_out.cap[2];
        crossbar_pkg::FN_SERIAL_RX,
        crossbar_pkg::FN_COUNT_IN,
        crossbar_pkg::FN_T0_IN,
        crossbar_pkg::FN_T1_IN:     begin
          next_out[p] = 1'b1;
          fn_oe[p]    = 1'b0;
        end
        default:                    next_out[p] = port_latch[p];
      endcase
      // Open-drain drives only low; push-pull drives both levels
      next_oe[p] = route_ctrl[`B_CROSSBAR_ON] && cfg.input_kind[p] && fn_oe[p]
                   && (cfg.driver_kind[p] || !next_out[p]);
      next_pu[p] = !route_ctrl[`B_PULLUP_OFF] && cfg.input_kind[p] && !cfg.driver_kind[p]
                   && !next_oe[p];
    end
  end

  // Registered pad controls
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_out    <= 16'hffff;
      pin_oe     <= 16'h0000;
      pin_pullup <= 16'hffff;
      pin_analog <= 16'h0000;
    end else begin
      pin_out    <= next_out;
      pin_oe     <= next_oe;
      pin_pullup <= next_pu;
      pin_analog <= ~cfg.input_kind;
    end
  end

  // Input receivers: analog pins read zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_seen <= 16'h0000;
    end else begin
      pin_seen <= pin_in & cfg.input_kind;
    end
  end

  // Return routed inputs to peripherals; idle level high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      periph_in <= '1;
    end else begin
      periph_in <= '1;
      for (int p = 0; p < 16; p++) begin
        if (route_ctrl[`B_CROSSBAR_ON]) begin
          unique case (pin_func[p])
            crossbar_pkg::FN_SERIAL_RX: periph_in.serial_rx <= pin_seen[p];
            crossbar_pkg::FN_SPI_SCK:   periph_in.spi_sck   <= pin_seen[p];
            crossbar_pkg::FN_SPI_MISO:  periph_in.spi_miso  <= pin_seen[p];
            crossbar_pkg::FN_SPI_MOSI:  periph_in.spi_mosi  <= pin_seen[p];
            crossbar_pkg::FN_SPI_NSS:   periph_in.spi_nss   <= pin_seen[p];
            crossbar_pkg::FN_CAP0:      periph_in.cap[0]    <= pin_seen[p];
            crossbar_pkg::FN_CAP1:      periph_in.cap[1]    <= pin_seen[p];
            crossbar_pkg::FN_CAP2:      periph_in.cap[2]    <= pin_seen[p];
            crossbar_pkg::FN_COUNT_IN:  periph_in.count_in  <= pin_seen[p];
            crossbar_pkg::FN_T0_IN:     periph_in.t0_in     <= pin_seen[p];
            crossbar_pkg::FN_T1_IN:     periph_in.t1_in     <= pin_seen[p];
            default: ;
          endcase
        end
      end
    end
  end
endmodule : priority_pin_crossbar
`default_nettype wire

// ---- test/priority_pin_crossbar_monitor.sv ----
/* Checker of pad and register bus timing for the pin crossbar.
   Assumes it is bound to priority_pin_crossbar and sees only its ports. */
`default_nettype none
module priority_pin_crossbar_monitor (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pin_pullup,
  input wire logic [15:0] pin_analog
);
  timeunit 1ns;
  timeprecision 1ns;
  logic touched;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Set once software has written anything
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      touched <= 1'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      touched <= 1'h1;
    end
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_analog_quiet: assert property ((pin_analog & (pin_pullup | pin_oe)) == 16'h0000)
    else $error("analog pin pulled or driven");
  chk_pullup_low_off: assert property ((pin_oe & ~pin_out & pin_pullup) == 16'h0000)
    else $error("pullup on a pin driving low");
  chk_idle_reset: assert property (!touched |-> pin_oe == 16'h0000 && pin_analog == 16'h0000)
    else $error("pins active before any write");
  chk_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("no write response");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("no read response");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
endmodule : priority_pin_crossbar_monitor
bind priority_pin_crossbar priority_pin_crossbar_monitor i_priority_pin_crossbar_monitor (
  .core_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .pin_out, .pin_oe, .pin_pullup, .pin_analog);
`default_nettype wire

// ---- test/pin_board.sv ----
/* Pad model: external circuitry seen by the sixteen crossbar pins.
   Assumes pad controls from the crossbar and an optional bench driver. */
`default_nettype none
module pin_board (
  input  wire logic        core_clk,
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] pin_pullup,
  input  wire logic [15:0] ext_en,
  input  wire logic [15:0] ext_val,
  output logic [15:0]      pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] drift = 16'h5555;
  // Floating pads change every cycle, never a stale level
  always @(posedge core_clk) drift <= ~drift;
  // Own driver first, then the external one, then the pullup
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pin_pullup | drift));
endmodule : pin_board
`default_nettype wire

// ---- test/tb_priority_pin_crossbar.sv ----
/* Testbench for the pin crossbar: registers, pad modes and priority routing.
   Assumes the design, the pad model and the checker are compiled before it. */
`default_nettype none
module tb_priority_pin_crossbar;
  timeunit 1ns;
  timeprecision 1ns;
  logic                      core_clk = 1'h0;
  logic                      rstn = 1'h0;
  logic                      variant_b = 1'h0;
  logic                      s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic                      s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic                      s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]                s_axi_bresp, s_axi_rresp;
  logic [9:0]                s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [31:0]               s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]                s_axi_wstrb = 4'h0;
  logic [15:0]               ext_en = 16'h0000, ext_val = 16'h0000;
  logic [15:0]               pin_in, pin_out, pin_oe, pin_pullup, pin_analog;
  crossbar_pkg::periph_out_t periph_out = '1;
  crossbar_pkg::periph_in_t  periph_in;
  int                        n_fail = 0, total_checks = 0;
  logic [31:0]               seed = 32'he0ef;

  // Clock of 100 ns
  always #50 core_clk = ~core_clk;

  priority_pin_crossbar i_priority_pin_crossbar (.core_clk, .rstn, .variant_b, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_out, .periph_in, .pin_in,
    .pin_out, .pin_oe, .pin_pullup, .pin_analog);
  pin_board i_pin_board (.core_clk, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val, .pin_in);

  function automatic logic [31:0] xrand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xrand

  // Pin that the clock output lands on, none if all are used
  function automatic logic [15:0] sys_mask(input logic [2:0] rs, input logic fw, input logic vb,
                                           input logic [15:0] byp);
    logic [15:0] taken;
    int          left;
    taken = byp | (rs[0] ? (vb ? 16'h0018 : 16'h0030) : 16'h0000);
    left = (rs[1] ? (fw ? 4 : 3) : 0) + int'(rs[2]);
    for (int p = 0; p < 16; p++) begin
      if (!taken[p] && left == 0) return 16'h0001 << p;
      if (!taken[p]) left--;
    end
    return 16'h0000;
  endfunction : sys_mask

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic limit(input int n);
    if (n >= 50) begin
      n_fail++;
      results();
    end
  endtask : limit

  // Register write by word index; bready stands until the response
  task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= {16'h0000, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    s_axi_bready <= 1'h0;
    limit(n);
  endtask : wr

  // Register read by word index; data taken at the edge rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    limit(n);
  endtask : rd

  // Main sequence
  initial begin : main
    logic [31:0]               d;
    logic [1:0]                r;
    logic [15:0]               kind, drv, lat, byp, ev, oe;
    logic [7:0]                rs;
    crossbar_pkg::periph_out_t po;
    logic [7:0]                ra [5];
    logic [15:0]               rv [5];
    ra = '{8'he1, 8'he2, 8'h02, 8'h03, 8'h04};
    rv = '{16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000};
    repeat (5) @(posedge core_clk);
    rstn <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], d, r);
      cmp_val(d[15:0], rv[i]);
    end
    rd(8'h08, d, r);
    cmp_val(16'(r), 16'h0002);
    cmp_val(d[15:0], 16'h0000);
    // Routes and drivers set while the crossbar is still off
    wr(8'h03, 16'hffff, 4'h3);
    wr(8'h00, 16'h0000, 4'h1);
    wr(8'he1, 16'h003f, 4'h1);
    wr(8'he2, 16'h00bb, 4'h1);
    cmp_val(16'(s_axi_bresp), 16'h0000);
    rd(8'he1, d, r);
    cmp_val(d[15:0], 16'h003f);
    rd(8'he2, d, r);
    cmp_val(d[15:0], 16'h00bb);
    repeat (2) @(posedge core_clk);
    cmp_val(pin_oe, 16'h0000);
    cmp_val(16'(periph_in), 16'h07ff);
    // Random pad modes with nothing routed
    wr(8'he1, 16'h0000, 4'h1);
    ext_en <= 16'hffff;
    for (int i = 0; i < 6; i++) begin
      kind = 16'(xrand());
      drv = 16'(xrand());
      lat = 16'(xrand());
      ev = 16'(xrand());
      rs = (8'(xrand()) & 8'h80) | 8'h40;
      ext_val <= ev;
      wr(8'h02, kind, 4'h3);
      wr(8'h03, drv, 4'h3);
      wr(8'h00, lat & 16'h00ff, 4'h1);
      wr(8'h01, lat >> 8, 4'h1);
      wr(8'he2, 16'(rs), 4'h1);
      repeat (2) @(posedge core_clk);
      oe = kind & (drv | ~lat);
      cmp_val(pin_oe, oe);
      cmp_val(pin_out & oe, lat & oe);
      cmp_val(pin_pullup, kind & ~drv & lat & {16{~rs[7]}});
      cmp_val(pin_analog, ~kind);
      rd(8'h00, d, r);
      cmp_val(d[15:0] & 16'h00ff, ((oe & lat) | (~oe & ev)) & kind & 16'h00ff);
    end
    // Clock output placed behind random higher-ranked functions
    wr(8'h02, 16'hffff, 4'h3);
    wr(8'h03, 16'hffff, 4'h3);
    wr(8'h00, 16'h00ff, 4'h1);
    wr(8'h01, 16'h00ff, 4'h1);
    ext_en <= 16'h0000;
    po = '1;
    po.system_clock_signal = 1'h0;
    periph_out <= po;
    for (int i = 0; i < 12; i++) begin
      rs = 8'(xrand()) & 8'h07;
      byp = 16'(xrand() & xrand());
      d = xrand();
      if (i == 0) begin
        rs = 8'h00;
        byp = 16'h7fff;
      end
      if (rs[0]) byp = byp | (d[0] ? 16'h0018 : 16'h0030);
      variant_b <= d[0];
      wr(8'h04, byp, 4'h3);
      wr(8'h06, {14'h0, d[1], 1'h0}, 4'h1);
      wr(8'he1, 16'(rs | 8'h08), 4'h1);
      wr(8'he2, 16'h0040, 4'h1);
      repeat (2) @(posedge core_clk);
      cmp_val(pin_oe & ~pin_out, sys_mask(rs[2:0], d[1], d[0], byp));
    end
    results();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    results();
  end
endmodule : tb_priority_pin_crossbar
`default_nettype wire
